// [design/dcd_decoder.sv]
/*
  command decoder: samples the command/address pins each rising edge and
  reports the decoded command, its fields and the power state.
  assumes pins are synchronous to clock and the controller keeps its side.
*/
`timescale 1ns/1ns
// widths and encodings come from the shared header; the guard makes a second include harmless
`include "dcd_consts.svh"
module dcd_decoder
  import dcd_pkg::*;
(
  input wire logic clock, // device clock
  input wire logic resetn, // async reset, active low
  input wire dcd_pins_s pins, // command/address pins
  input wire logic odt, // termination request
  input wire logic otf_mode, // mode register: burst length chosen per command
  input wire logic fixed_bc4, // mode register: fixed burst chop 4
  output dcd_cmd_s cmd_out, // decoded command, registered
  output logic cmd_valid, // one-cycle pulse per decoded command
  output logic burst_busy, // burst in progress
  output logic odt_on, // termination enabled
  output logic refresh_go, // one-cycle pulse: refresh executed
  output dcd_state_e pwr_state // power state
);
  logic cke_prev_reg, cke_prev_next;
  dcd_cmd_s cmd_reg, cmd_next;
  logic valid_reg, valid_next;
  dcd_state_e st_reg, st_next;
  logic [2:0] burst_cnt_reg, burst_cnt_next;
  logic ref_reg, ref_next;
  logic [2:0] rcw;

  always_comb
  begin
    rcw = pins.addr[16:14];
    cke_prev_next = pins.cke;
    cmd_next = '0;
    cmd_next.cmd = DCD_CMD_NONE;
    cmd_next.bg = pins.bg;
    cmd_next.ba = pins.ba;
    cmd_next.col = pins.addr[`DCD_COL_W-1:0];
    cmd_next.auto_pre = pins.addr[`DCD_A10];
    st_next = st_reg;
    valid_next = 1'b0;
    ref_next = 1'b0;
    if (cke_prev_reg && pins.cke)
    begin
      if (pins.cs_n)
        cmd_next.cmd = DCD_CMD_DES;
      else if (!pins.act_n)
      begin
        cmd_next.cmd = DCD_CMD_ACT;
        cmd_next.row = pins.addr[`DCD_ADDR_W-2:0];
      end
      else
        case (rcw)
          `DCD_RCW_MRS:
          begin
            cmd_next.cmd = DCD_CMD_MRS;
            // bank bits pick the register; a17 is left out of the opcode
            cmd_next.mrs_op = {pins.bg, pins.ba, 1'b0, pins.addr[13:0]};
          end
          `DCD_RCW_REF:
          begin
            cmd_next.cmd = DCD_CMD_REF;
            ref_next = (st_reg == DCD_ST_ACTIVE);
          end
          `DCD_RCW_PRE: cmd_next.cmd = pins.addr[`DCD_A10] ? DCD_CMD_PREA : DCD_CMD_PRE;
          `DCD_RCW_RFU: cmd_next.cmd = DCD_CMD_RFU;
          `DCD_RCW_WR: cmd_next.cmd = DCD_CMD_WR;
          `DCD_RCW_RD: cmd_next.cmd = DCD_CMD_RD;
          `DCD_RCW_ZQ: cmd_next.cmd = pins.addr[`DCD_A10] ? DCD_CMD_ZQCL : DCD_CMD_ZQCS;
          `DCD_RCW_NOP: cmd_next.cmd = DCD_CMD_NOP;
          default: cmd_next.cmd = DCD_CMD_ILL;
        endcase
      if (cmd_next.cmd == DCD_CMD_WR || cmd_next.cmd == DCD_CMD_RD)
        cmd_next.chop4 = otf_mode ? !pins.addr[`DCD_A12] : fixed_bc4;
    end
    else if (cke_prev_reg && !pins.cke)
    begin
      if (!pins.cs_n && pins.act_n && rcw == `DCD_RCW_REF)
      begin
        cmd_next.cmd = DCD_CMD_SRE;
        st_next = DCD_ST_SR;
      end
      else if (pins.cs_n)
      begin
        cmd_next.cmd = DCD_CMD_PDE;
        st_next = DCD_ST_PD;
      end
      else
        cmd_next.cmd = DCD_CMD_ILL;
    end
    else if (!cke_prev_reg && pins.cke)
    begin
      // exit seen on the clock edge only; asynchronous exit not used
      if (pins.cs_n || (pins.act_n && rcw == `DCD_RCW_NOP))
      begin
        cmd_next.cmd = (st_reg == DCD_ST_SR) ? DCD_CMD_SRX : DCD_CMD_PDX;
        st_next = DCD_ST_ACTIVE;
      end
      else
        cmd_next.cmd = DCD_CMD_ILL;
    end
    valid_next = (cmd_next.cmd != DCD_CMD_NONE);
  end

  // burst counter: no command shortens a running burst
  always_comb
  begin
    burst_cnt_next = burst_cnt_reg;
    if (burst_cnt_reg != 3'h0)
      burst_cnt_next = burst_cnt_reg - 3'h1;
    else if (cmd_next.cmd == DCD_CMD_WR || cmd_next.cmd == DCD_CMD_RD)
      burst_cnt_next = 3'(`DCD_BURST_CYC);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cke_prev_reg <= 1'b0;
      cmd_reg <= '0;
      valid_reg <= 1'b0;
      st_reg <= DCD_ST_ACTIVE;
      burst_cnt_reg <= 3'h0;
      ref_reg <= 1'b0;
    end
    else
    begin
      cke_prev_reg <= cke_prev_next;
      cmd_reg <= cmd_next;
      valid_reg <= valid_next;
      st_reg <= st_next;
      burst_cnt_reg <= burst_cnt_next;
      ref_reg <= ref_next;
    end
  end

  assign cmd_out = cmd_reg;
  assign cmd_valid = valid_reg;
  assign burst_busy = (burst_cnt_reg != 3'h0);
  assign refresh_go = ref_reg;
  assign pwr_state = st_reg;
  // command decode never looks at odt; only power state gates it
  assign odt_on = odt && (st_reg != DCD_ST_SR);

  a_act_decode: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && pins.cke && !pins.cs_n && !pins.act_n) |=>
    (cmd_reg.cmd == DCD_CMD_ACT && cmd_reg.row == $past(pins.addr[16:0])))
    else $error("activate not decoded");
  a_des_decode: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && pins.cke && pins.cs_n) |=> cmd_reg.cmd == DCD_CMD_DES)
    else $error("deselect not decoded");
  a_otf_chop: assert property (@(posedge clock) disable iff (!resetn)
    (valid_reg && cmd_reg.cmd == DCD_CMD_RD && $past(otf_mode)) |->
    cmd_reg.chop4 == !$past(pins.addr[12]))
    else $error("otf burst length wrong");
  a_fixed_len: assert property (@(posedge clock) disable iff (!resetn)
    (valid_reg && cmd_reg.cmd == DCD_CMD_WR && !$past(otf_mode)) |->
    cmd_reg.chop4 == $past(fixed_bc4))
    else $error("fixed burst length wrong");
  a_burst_full: assert property (@(posedge clock) disable iff (!resetn)
    $rose(burst_busy) |-> burst_busy [*4] ##1 !burst_busy)
    else $error("burst cut short");
  a_sr_odt_off: assert property (@(posedge clock) disable iff (!resetn)
    pwr_state == DCD_ST_SR |-> !odt_on)
    else $error("odt on in self refresh");
  a_pd_no_ref: assert property (@(posedge clock) disable iff (!resetn)
    $past(pwr_state) == DCD_ST_PD |-> !refresh_go)
    else $error("refresh in power-down");
  a_mrs_a17: assert property (@(posedge clock) disable iff (!resetn)
    (valid_reg && cmd_reg.cmd == DCD_CMD_MRS) |->
    (cmd_reg.mrs_op[14] == 1'b0 && cmd_reg.mrs_op[18:15] == $past({pins.bg, pins.ba})))
    else $error("mrs field mapping wrong");
  a_sre_enter: assert property (@(posedge clock) disable iff (!resetn)
    (cmd_reg.cmd == DCD_CMD_SRE && valid_reg) |-> pwr_state == DCD_ST_SR)
    else $error("self refresh not entered");
  a_mrs_decode: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && pins.cke && !pins.cs_n && pins.act_n &&
    pins.addr[16:14] == `DCD_RCW_MRS) |=>
    cmd_reg.cmd == DCD_CMD_MRS)
    else $error("mode register set not decoded");
  a_ref_decode: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && pins.cke && !pins.cs_n && pins.act_n &&
    pins.addr[16:14] == `DCD_RCW_REF) |=>
    cmd_reg.cmd == DCD_CMD_REF)
    else $error("refresh not decoded");
  a_pre_decode: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && pins.cke && !pins.cs_n && pins.act_n &&
    pins.addr[16:14] == `DCD_RCW_PRE) |=>
    cmd_reg.cmd == ($past(pins.addr[10]) ? DCD_CMD_PREA : DCD_CMD_PRE))
    else $error("precharge not decoded");
  a_wr_decode: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && pins.cke && !pins.cs_n && pins.act_n &&
    pins.addr[16:14] == `DCD_RCW_WR) |=>
    (cmd_reg.cmd == DCD_CMD_WR && cmd_reg.col == $past(pins.addr[9:0])))
    else $error("write not decoded");
  a_rd_autopre: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && pins.cke && !pins.cs_n && pins.act_n &&
    pins.addr[16:14] == `DCD_RCW_RD) |=>
    (cmd_reg.cmd == DCD_CMD_RD && cmd_reg.auto_pre == $past(pins.addr[10])))
    else $error("read or auto-precharge not decoded");
  a_zq_decode: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && pins.cke && !pins.cs_n && pins.act_n &&
    pins.addr[16:14] == `DCD_RCW_ZQ) |=>
    cmd_reg.cmd == ($past(pins.addr[10]) ? DCD_CMD_ZQCL : DCD_CMD_ZQCS))
    else $error("calibration length not decoded");
  a_bank_select: assert property (@(posedge clock) disable iff (!resetn)
    (valid_reg && (cmd_reg.cmd == DCD_CMD_ACT || cmd_reg.cmd == DCD_CMD_RD ||
    cmd_reg.cmd == DCD_CMD_WR || cmd_reg.cmd == DCD_CMD_PRE)) |->
    {cmd_reg.bg, cmd_reg.ba} == $past({pins.bg, pins.ba}))
    else $error("bank select wrong");
  a_pde_enter: assert property (@(posedge clock) disable iff (!resetn)
    ($past(pins.cke) && !pins.cke && pins.cs_n) |=>
    (cmd_reg.cmd == DCD_CMD_PDE && pwr_state == DCD_ST_PD))
    else $error("power-down not entered");
  a_otf_wr_chop: assert property (@(posedge clock) disable iff (!resetn)
    (valid_reg && cmd_reg.cmd == DCD_CMD_WR && $past(otf_mode)) |->
    cmd_reg.chop4 == !$past(pins.addr[12]))
    else $error("otf write burst length wrong");
  a_fixed_rd_len: assert property (@(posedge clock) disable iff (!resetn)
    (valid_reg && cmd_reg.cmd == DCD_CMD_RD && !$past(otf_mode)) |->
    cmd_reg.chop4 == $past(fixed_bc4))
    else $error("fixed read burst length wrong");
  a_exit_sync: assert property (@(posedge clock) disable iff (!resetn)
    (!$past(pins.cke) && pins.cke && pins.cs_n) |=>
    ((cmd_reg.cmd == DCD_CMD_SRX || cmd_reg.cmd == DCD_CMD_PDX) && pwr_state == DCD_ST_ACTIVE))
    else $error("low-power exit not decoded");
endmodule : dcd_decoder

// [shared/dcd_consts.svh]
/*
  constants for the command decoder: encodings, field positions, widths.
  assumes the includer compiles it once per unit; guarded.
*/
`ifndef DCD_CONSTS_SVH
`define DCD_CONSTS_SVH
`define DCD_BG_W 2
`define DCD_BA_W 2
`define DCD_ADDR_W 18
`define DCD_COL_W 10
`define DCD_A10 10
`define DCD_A12 12
`define DCD_A17 17
`define DCD_OP_W 17
`define DCD_BURST_CYC 4
`define DCD_RCW_MRS 3'h0
`define DCD_RCW_REF 3'h1
`define DCD_RCW_PRE 3'h2
`define DCD_RCW_RFU 3'h3
`define DCD_RCW_WR 3'h4
`define DCD_RCW_RD 3'h5
`define DCD_RCW_ZQ 3'h6
`define DCD_RCW_NOP 3'h7
`endif

// [shared/dcd_pkg.sv]
/*
  types for the command decoder.
  assumes dcd_consts.svh sits in the include path.
*/
`include "dcd_consts.svh"
package dcd_pkg;
  typedef enum logic [4:0] {
    DCD_CMD_NONE = 5'h00, DCD_CMD_MRS = 5'h01, DCD_CMD_REF = 5'h02,
    DCD_CMD_SRE = 5'h03, DCD_CMD_SRX = 5'h04, DCD_CMD_PRE = 5'h05,
    DCD_CMD_PREA = 5'h06, DCD_CMD_ACT = 5'h07, DCD_CMD_WR = 5'h08,
    DCD_CMD_RD = 5'h09, DCD_CMD_NOP = 5'h0a, DCD_CMD_DES = 5'h0b,
    DCD_CMD_PDE = 5'h0c, DCD_CMD_PDX = 5'h0d, DCD_CMD_ZQCL = 5'h0e,
    DCD_CMD_ZQCS = 5'h0f, DCD_CMD_RFU = 5'h10, DCD_CMD_ILL = 5'h11
  } dcd_cmd_e;
  typedef enum logic [1:0] {
    DCD_ST_ACTIVE = 2'b00, DCD_ST_PD = 2'b01, DCD_ST_SR = 2'b10
  } dcd_state_e;
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic act_n;
    logic [`DCD_BG_W-1:0] bg;
    logic [`DCD_BA_W-1:0] ba;
    logic [`DCD_ADDR_W-1:0] addr;
  } dcd_pins_s;
  typedef struct packed {
    dcd_cmd_e cmd;
    logic [`DCD_BG_W-1:0] bg;
    logic [`DCD_BA_W-1:0] ba;
    logic [`DCD_ADDR_W-2:0] row;
    logic [`DCD_COL_W-1:0] col;
    logic [`DCD_OP_W+1:0] mrs_op;
    logic auto_pre;
    logic chop4;
  } dcd_cmd_s;
endpackage : dcd_pkg

// [bench/dcd_ctl_model.sv]
/*
  controller model: drives the decoder's command/address pins.
  assumes the bench calls send just after a falling edge of clock.
*/
`timescale 1ns/1ns
module dcd_ctl_model
  import dcd_pkg::*;
(
  clock, // device clock
  pins // command/address pins
);
  input wire logic clock;
  output dcd_pins_s pins;
  initial pins = '0;
  // every field gets a fresh defined level, so stale values cannot mask a decode
  task automatic send(input logic c, input logic cs, input logic act,
    input logic [2:0] k, input logic [21:0] r);
    dcd_pins_s p;
    p = {c, cs, act, r};
    if (act)
      p.addr[16:14] = k;
    pins = p;
  endtask : send
endmodule : dcd_ctl_model

// [bench/ddr4_command_decoder_tb.sv]
/*
  testbench: fixed command sequence with random address and odt against a small integer model.
  assumes the decoder answers on each sampling edge, before the following falling edge.
*/
`timescale 1ns/1ns
module ddr4_command_decoder_tb;
  import dcd_pkg::*;
  logic clock = 0;
  logic resetn = 0;
  logic odt = 0;
  logic otf_mode = 1;
  logic fixed_bc4 = 0;
  dcd_pins_s pins;
  dcd_cmd_s cmd_out;
  logic cmd_valid, burst_busy, odt_on, refresh_go;
  dcd_state_e pwr_state;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int st = 0;
  int pc = 0;
  int bc = 0;
  dcd_cmd_e tbl[8] = '{DCD_CMD_MRS, DCD_CMD_REF, DCD_CMD_PRE, DCD_CMD_RFU,
    DCD_CMD_WR, DCD_CMD_RD, DCD_CMD_ZQCS, DCD_CMD_NOP};
  always #25 clock = ~clock;
  dcd_ctl_model ctl (.clock(clock), .pins(pins));
  dcd_decoder DUT (.clock(clock), .resetn(resetn), .pins(pins), .odt(odt),
    .otf_mode(otf_mode), .fixed_bc4(fixed_bc4), .cmd_out(cmd_out),
    .cmd_valid(cmd_valid), .burst_busy(burst_busy), .odt_on(odt_on),
    .refresh_go(refresh_go), .pwr_state(pwr_state));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk_cmd(input dcd_cmd_e e, input dcd_cmd_e s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch cmd expected %s seen %s", e.name(), s.name());
    end
  endtask : chk_cmd
  task automatic chk_fld(input string n, input logic [18:0] e, input logic [18:0] s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk_fld
  task automatic step(input logic c, input logic cs, input logic act, input logic [2:0] k);
    logic [21:0] r;
    dcd_cmd_e e;
    int s0;
    r = 22'($urandom);
    odt = 1'($urandom);
    e = DCD_CMD_NONE;
    s0 = st;
    if (pc == 1 && c)
      e = cs ? DCD_CMD_DES : !act ? DCD_CMD_ACT : tbl[k];
    if (e == DCD_CMD_PRE && r[10]) e = DCD_CMD_PREA;
    if (e == DCD_CMD_ZQCS && r[10]) e = DCD_CMD_ZQCL;
    if (pc == 1 && !c)
      e = cs ? DCD_CMD_PDE : (act && k == 3'h1) ? DCD_CMD_SRE : DCD_CMD_ILL;
    if (pc == 0 && c)
      e = (cs || (act && k == 3'h7)) ? (st == 2 ? DCD_CMD_SRX : DCD_CMD_PDX) : DCD_CMD_ILL;
    st = e == DCD_CMD_SRE ? 2 : e == DCD_CMD_PDE ? 1 : (e == DCD_CMD_SRX || e == DCD_CMD_PDX) ? 0 : st;
    // a running burst is never restarted or cut by a later command
    bc = bc > 0 ? bc - 1 : (e == DCD_CMD_RD || e == DCD_CMD_WR) ? 4 : 0;
    pc = c;
    ctl.send(c, cs, act, k, r);
    @(negedge clock);
    chk_cmd(e, cmd_out.cmd);
    chk_fld("valid", 19'(e != DCD_CMD_NONE), 19'(cmd_valid));
    chk_fld("refresh", 19'(e == DCD_CMD_REF && s0 == 0), 19'(refresh_go));
    chk_fld("state", 19'(st), 19'(pwr_state));
    chk_fld("odt", 19'(odt && st != 2), 19'(odt_on));
    chk_fld("busy", 19'(bc > 0), 19'(burst_busy));
    if (e == DCD_CMD_RD || e == DCD_CMD_WR)
    begin
      chk_fld("chop4", 19'(otf_mode ? !r[12] : fixed_bc4), 19'(cmd_out.chop4));
      chk_fld("ap", 19'(r[10]), 19'(cmd_out.auto_pre));
      chk_fld("col", 19'(r[9:0]), 19'(cmd_out.col));
    end
    if (e == DCD_CMD_ACT)
      chk_fld("row", 19'(r[16:0]), 19'(cmd_out.row));
    if (e inside {DCD_CMD_ACT, DCD_CMD_RD, DCD_CMD_WR, DCD_CMD_PRE, DCD_CMD_MRS})
      chk_fld("bank", 19'(r[21:18]), 19'({cmd_out.bg, cmd_out.ba}));
    if (e == DCD_CMD_MRS)
      chk_fld("op", {r[21:18], 1'b0, r[13:0]}, cmd_out.mrs_op);
  endtask : step
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(32'h12da));
    repeat (10) @(negedge clock);
    chk_fld("rst", 19'h0, 19'(pwr_state));
    chk_fld("rst valid", 19'h0, 19'(cmd_valid));
    resetn = 1;
    step(1, 1, 1, 3'h0);
    for (int m = 0; m < 4; m++)
    begin
      otf_mode = m[0];
      fixed_bc4 = m[1];
      for (int k = 0; k < 8; k++)
      begin
        step(1, 0, 1, 3'(k));
        repeat (4) step(1, 1, 1, 3'h0);
      end
      step(1, 0, 0, 3'h0);
    end
    $display("test commands done");
    step(0, 1, 1, 3'h0);
    step(0, 0, 1, 3'h1);
    step(1, 1, 1, 3'h0);
    step(0, 1, 1, 3'h0);
    step(1, 1, 1, 3'h0);
    // refused exit leaves the block in power-down, so a refresh there must not run
    step(0, 1, 1, 3'h0);
    step(1, 0, 1, 3'h1);
    step(1, 0, 1, 3'h1);
    step(0, 1, 1, 3'h0);
    step(1, 1, 1, 3'h0);
    step(0, 0, 1, 3'h0);
    step(1, 1, 1, 3'h0);
    $display("test power-down done");
    repeat (8) step(1, 1, 1, 3'h0);
    step(0, 0, 1, 3'h1);
    repeat (3) step(0, 1, 1, 3'h0);
    step(1, 1, 1, 3'h0);
    step(1, 1, 1, 3'h0);
    step(0, 0, 1, 3'h1);
    step(0, 1, 1, 3'h0);
    step(1, 0, 1, 3'h7);
    step(1, 1, 1, 3'h0);
    $display("test self refresh done");
    conclude();
  end
endmodule : ddr4_command_decoder_tb
